// >>> logic/lmaa_pkg.sv
// Constants for the load monitor alarm and autoset block.
// Assumes a 100 MHz core clock and a byte-addressed register port.
package lmaa_pkg;
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int TENTH_NS      = 100_000_000;
   localparam int TENTH_CYCLES  = TENTH_NS / CLK_PERIOD_NS;
   localparam int TENTHS_PER_S  = 10;
   // Field widths
   localparam int LEVEL_W  = 8;
   localparam int MARGIN_W = 7;
   localparam int DELAY_W  = 10;
   localparam int START_W  = 10;
   localparam int ACT_W    = 3;
   localparam int ACT_FW   = 4;
   localparam int N_ALARM  = 6;
   localparam int N_LOAD   = 4;
   localparam int IRQ_W    = 8;
   localparam logic [7:0] LEVEL_MAX = 8'hC8;
   // Register byte addresses
   localparam logic [7:0] ADDR_LEVEL_BASE  = 8'h00;
   localparam logic [7:0] ADDR_DELAY_BASE  = 8'h10;
   localparam logic [7:0] ADDR_MARGIN_BASE = 8'h20;
   localparam logic [7:0] ADDR_START_DELAY = 8'h30;
   localparam logic [7:0] ADDR_ACTIONS     = 8'h34;
   localparam logic [7:0] ADDR_DI_ASSIGN   = 8'h38;
   localparam logic [7:0] ADDR_AUTOSET     = 8'h3C;
   localparam logic [7:0] ADDR_NORMAL_LOAD = 8'h40;
   localparam logic [7:0] ADDR_STATUS      = 8'h44;
   localparam logic [7:0] ADDR_IRQ_STAT    = 8'h48;
   localparam logic [7:0] ADDR_IRQ_MASK    = 8'h4C;
   // Reset values
   localparam logic [7:0]  HI_ALARM_LEVEL_RST = 8'h74;
   localparam logic [7:0]  HI_PRE_LEVEL_RST   = 8'h6C;
   localparam logic [7:0]  LO_PRE_LEVEL_RST   = 8'h5C;
   localparam logic [7:0]  LO_ALARM_LEVEL_RST = 8'h54;
   localparam logic [9:0]  DELAY_RST          = 10'h005;
   localparam logic [6:0]  ALARM_MARGIN_RST   = 7'h10;
   localparam logic [6:0]  PRE_MARGIN_RST     = 7'h08;
   localparam logic [9:0]  START_DELAY_RST    = 10'h00A;
   localparam logic [23:0] ACTIONS_RST        = 24'h110000;
   localparam logic [7:0]  IRQ_MASK_RST       = 8'h00;
   // Action codes
   localparam logic [2:0] ACT_NONE = 3'h0;
   localparam logic [2:0] ACT_HARD = 3'h1;
   localparam logic [2:0] ACT_SOFT = 3'h3;
   localparam logic [2:0] ACT_WARN = 3'h4;
   // Digital input functions
   localparam logic [1:0] DI_NONE    = 2'h0;
   localparam logic [1:0] DI_EXT1    = 2'h1;
   localparam logic [1:0] DI_EXT2    = 2'h2;
   localparam logic [1:0] DI_AUTOSET = 2'h3;
   // Autoset command and result bits
   localparam logic       AUTOSET_YES  = 1'b1;
   localparam int         NL_VALID_BIT = 8;
   localparam int         IRQ_AS_OK    = 6;
   localparam int         IRQ_AS_FAIL  = 7;
   localparam int         ST_START_BIT = 7;
   localparam int         ST_BASE_BIT  = 6;
endpackage

// >>> logic/lmaa_delay_timer.sv
// Qualification timer for one load threshold.
// Assumes tick is a one-cycle pulse every tenth of a second.
`timescale 1ns/10ps
`default_nettype none
module lmaa_delay_timer #(
   parameter int CNT_W = 10
) (
   input  wire logic             core_clk,
   input  wire logic             rst_b,
   input  wire logic             cond,
   input  wire logic             tick,
   input  wire logic [CNT_W-1:0] delay,
   output var  logic             fired
);
   logic [CNT_W-1:0] cnt_reg;

   // Count tenths while the violation holds; any lapse restarts it
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_reg <= '0;
      end else if (!cond) begin
         cnt_reg <= '0; // RULE17
      end else if (tick && cnt_reg < delay) begin
         cnt_reg <= cnt_reg + CNT_W'(1);
      end
   end

   // Fire only once the full delay has run without a break
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         fired <= 1'b0;
      end else begin
         fired <= cond && (cnt_reg >= delay); // RULE1 RULE15 RULE16
      end
   end

   a_timer_restart: assert property (@(posedge core_clk) disable iff (!rst_b)
      !cond |=> cnt_reg == '0 && !fired) // RULE17
      else $error("delay timer did not restart on lapse");
   a_fire_needs_cond: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      fired |-> $past(cond) && $past(cnt_reg) >= $past(delay)) // RULE1
      else $error("timer fired without full delay");
endmodule
`default_nettype wire

// >>> logic/lmaa_load_monitor.sv
// Load monitor alarms with autoset and external alarm inputs.
// Assumes shaft_power and run_cmd come from logic on core_clk;
// digital inputs are asynchronous pins.
// Functional notes
// RULE1 - Low alarm fires after uninterrupted delay
// RULE2 - Start delay masks load alarms after run
// RULE3 - Autoset captures power then recomputes levels
// RULE4 - High levels are baseline plus margins
// RULE5 - Low levels are baseline minus margins
// RULE6 - Margin writes leave active levels alone
// RULE7 - Manual level write turns baseline off
// RULE8 - Baseline read-only, Off at reset, 0-200 (autoset stores shaft_power unclamped, so up to 255)
// RULE9 - Autoset command: 0 No, 1 Yes
// RULE10 - Autoset fails if stopped or starting
// RULE11 - Autoset input acts on rising edge
// RULE12 - Inputs raise enabled external alarms
// RULE13 - Inputs on same alarm are ORed
// RULE14 - External action codes 0,1,3,4; hard default
// RULE15 - High alarms fire after their delay
// RULE16 - Low pre-alarm fires after its delay
// RULE17 - Timers restart when violation lapses
// RULE18 - Computed levels saturate, never wrap
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module lmaa_load_monitor #(
   parameter int N_DI        = 4,
   parameter int TICK_CYCLES = lmaa_pkg::TENTH_CYCLES
) (
   input  wire logic            core_clk,
   input  wire logic            rst_b,
   input  wire logic [7:0]      shaft_power,
   input  wire logic            run_cmd,
   input  wire logic [N_DI-1:0] din,
   input  wire logic [7:0]      addr,
   input  wire logic [31:0]     wdata,
   input  wire logic            wr_stb,
   input  wire logic            rd_stb,
   output var  logic [31:0]     rdata,
   output var  logic            irq,
   output var  logic            trip_hard,
   output var  logic            trip_soft,
   output var  logic            trip_warn,
   output var  logic [5:0]      alarm_active
);
   localparam int NA = lmaa_pkg::N_ALARM;
   localparam int NL = lmaa_pkg::N_LOAD;

   logic [7:0]       level_reg [NL];
   logic [9:0]       delay_reg [NL];
   logic [6:0]       margin_reg [NL];
   logic [9:0]       start_delay_reg;
   logic [23:0]      actions_reg;
   logic [2*N_DI-1:0] di_assign_reg;
   logic [7:0]       baseline_reg;
   logic             baseline_valid_reg;
   logic [7:0]       irq_stat_reg;
   logic [7:0]       irq_mask_reg;
   logic [31:0]      tick_cnt_reg;
   logic [13:0]      start_cnt_reg;
   logic             run_prev_reg;
   logic [N_DI-1:0]  di_s1_reg;
   logic [N_DI-1:0]  di_s2_reg;
   logic [N_DI-1:0]  di_prev_reg;
   logic [NA-1:0]    active_prev_reg;
   logic             tick;
   logic             start_done;
   logic             as_req;
   logic             as_ok;
   logic [N_DI-1:0]  as_edge;
   logic [1:0]       ext_req;
   logic [NL-1:0]    fired;
   logic [NA-1:0]    cond_act;
   localparam int IRQ_W_L = lmaa_pkg::IRQ_W;
   logic [IRQ_W_L-1:0] irq_ev;
   logic [13:0]      start_limit;
   logic             lvl_wr;
   logic             dly_wr;
   logic             mar_wr;
   logic [31:0]      rd_mux;

   // Saturating helpers so computed levels never wrap
   function automatic logic [7:0] sat_add(input logic [7:0] b,
                                          input logic [6:0] m);
      logic [8:0] s;
      s = {1'b0, b} + {2'b00, m};
      sat_add = (s > {1'b0, lmaa_pkg::LEVEL_MAX}) ? lmaa_pkg::LEVEL_MAX
                                                  : s[7:0]; // RULE18
   endfunction

   function automatic logic [7:0] sat_sub(input logic [7:0] b,
                                          input logic [6:0] m);
      sat_sub = (b > {1'b0, m}) ? b - {1'b0, m} : 8'h00; // RULE18
   endfunction

   // Register decode
   assign lvl_wr = wr_stb && addr[7:4] == lmaa_pkg::ADDR_LEVEL_BASE[7:4];
   assign dly_wr = wr_stb && addr[7:4] == lmaa_pkg::ADDR_DELAY_BASE[7:4];
   assign mar_wr = wr_stb && addr[7:4] == lmaa_pkg::ADDR_MARGIN_BASE[7:4];

   // Tenth-second prescaler shared by all timers
   assign tick = tick_cnt_reg == 32'(TICK_CYCLES - 1);
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         tick_cnt_reg <= 32'h0;
      end else begin
         tick_cnt_reg <= tick ? 32'h0 : tick_cnt_reg + 32'h1;
      end
   end

   // Start delay runs from the run command's rising edge
   assign start_limit = 14'({4'h0, start_delay_reg} * lmaa_pkg::TENTHS_PER_S);
   assign start_done  = run_cmd && run_prev_reg &&
                        start_cnt_reg >= start_limit;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         run_prev_reg  <= 1'b0;
         start_cnt_reg <= 14'h0;
      end else begin
         run_prev_reg <= run_cmd;
         if (!run_cmd || !run_prev_reg) begin
            start_cnt_reg <= 14'h0; // RULE2
         end else if (tick && start_cnt_reg < start_limit) begin
            start_cnt_reg <= start_cnt_reg + 14'h1;
         end
      end
   end

   // Two-stage pin synchroniser, then a delayed copy for edges
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         di_s1_reg   <= '0;
         di_s2_reg   <= '0;
         di_prev_reg <= '0;
      end else begin
         di_s1_reg   <= din;
         di_s2_reg   <= di_s1_reg;
         di_prev_reg <= di_s2_reg;
      end
   end

   // Input functions: autoset edges and ORed external alarms
   always_comb begin
      ext_req = 2'b00;
      as_edge = '0;
      for (int k = 0; k < N_DI; k++) begin
         if (di_assign_reg[2*k +: 2] == lmaa_pkg::DI_EXT1) begin
            ext_req[0] = ext_req[0] | di_s2_reg[k]; // RULE13
         end
         if (di_assign_reg[2*k +: 2] == lmaa_pkg::DI_EXT2) begin
            ext_req[1] = ext_req[1] | di_s2_reg[k]; // RULE13
         end
         if (di_assign_reg[2*k +: 2] == lmaa_pkg::DI_AUTOSET) begin
            as_edge[k] = di_s2_reg[k] & ~di_prev_reg[k]; // RULE11
         end
      end
   end

   // Autoset only succeeds once the motor runs past its start delay
   assign as_req = (wr_stb && addr == lmaa_pkg::ADDR_AUTOSET &&
                    wdata[0] == lmaa_pkg::AUTOSET_YES) || |as_edge; // RULE9
   assign as_ok  = as_req && start_done; // RULE10

   // Levels: autoset recompute wins over a manual write in one cycle
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         level_reg[0]       <= lmaa_pkg::HI_ALARM_LEVEL_RST;
         level_reg[1]       <= lmaa_pkg::HI_PRE_LEVEL_RST;
         level_reg[2]       <= lmaa_pkg::LO_PRE_LEVEL_RST;
         level_reg[3]       <= lmaa_pkg::LO_ALARM_LEVEL_RST;
         baseline_reg       <= 8'h00;
         baseline_valid_reg <= 1'b0; // RULE8
      end else if (as_ok) begin
         baseline_reg       <= shaft_power; // RULE3
         baseline_valid_reg <= 1'b1;
         level_reg[0] <= sat_add(shaft_power, margin_reg[0]); // RULE4
         level_reg[1] <= sat_add(shaft_power, margin_reg[1]); // RULE4
         level_reg[2] <= sat_sub(shaft_power, margin_reg[2]); // RULE5
         level_reg[3] <= sat_sub(shaft_power, margin_reg[3]); // RULE5
      end else if (lvl_wr) begin
         level_reg[addr[3:2]] <= (wdata[7:0] > lmaa_pkg::LEVEL_MAX) ?
                                 lmaa_pkg::LEVEL_MAX : wdata[7:0];
         baseline_reg         <= 8'h00; // Off reads as all zero
         baseline_valid_reg   <= 1'b0; // RULE7
      end
   end

   // Margins only feed the next autoset, never the live levels
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         margin_reg[0] <= lmaa_pkg::ALARM_MARGIN_RST;
         margin_reg[1] <= lmaa_pkg::PRE_MARGIN_RST;
         margin_reg[2] <= lmaa_pkg::PRE_MARGIN_RST;
         margin_reg[3] <= lmaa_pkg::ALARM_MARGIN_RST;
      end else if (mar_wr) begin
         margin_reg[addr[3:2]] <= wdata[6:0]; // RULE6
      end
   end

   // Plain configuration registers
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < NL; i++) begin
            delay_reg[i] <= lmaa_pkg::DELAY_RST;
         end
         start_delay_reg <= lmaa_pkg::START_DELAY_RST;
         actions_reg     <= lmaa_pkg::ACTIONS_RST; // RULE14
         di_assign_reg   <= '0;
         irq_mask_reg    <= lmaa_pkg::IRQ_MASK_RST;
      end else if (wr_stb) begin
         if (dly_wr) begin
            delay_reg[addr[3:2]] <= wdata[9:0];
         end
         if (addr == lmaa_pkg::ADDR_START_DELAY) begin
            start_delay_reg <= wdata[9:0];
         end
         if (addr == lmaa_pkg::ADDR_ACTIONS) begin
            actions_reg <= wdata[23:0];
         end
         if (addr == lmaa_pkg::ADDR_DI_ASSIGN) begin
            di_assign_reg <= wdata[2*N_DI-1:0];
         end
         if (addr == lmaa_pkg::ADDR_IRQ_MASK) begin
            irq_mask_reg <= wdata[7:0];
         end
      end
   end

   // One qualified condition per alarm; load alarms wait on start delay
   for (genvar i = 0; i < NA; i++) begin : g_alarm
      if (i < NL) begin : g_load
         logic viol;
         assign viol = (i < 2) ? shaft_power > level_reg[i]
                               : shaft_power < level_reg[i];
         lmaa_delay_timer #(
            .CNT_W (lmaa_pkg::DELAY_W)
         ) u_timer (
            .core_clk (core_clk),
            .rst_b    (rst_b),
            .cond     (viol && start_done), // RULE2
            .tick     (tick),
            .delay    (delay_reg[i]),
            .fired    (fired[i])
         );
         assign cond_act[i] = fired[i] &&
            actions_reg[i*lmaa_pkg::ACT_FW +: 3] != lmaa_pkg::ACT_NONE;
      end else begin : g_ext
         assign cond_act[i] = ext_req[i-NL] &&
            actions_reg[i*lmaa_pkg::ACT_FW +: 3] != lmaa_pkg::ACT_NONE; // RULE12
      end
   end

   // Registered alarm and action outputs
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         alarm_active    <= '0;
         active_prev_reg <= '0;
         trip_hard       <= 1'b0;
         trip_soft       <= 1'b0;
         trip_warn       <= 1'b0;
      end else begin
         alarm_active    <= cond_act;
         active_prev_reg <= alarm_active;
         trip_hard       <= 1'b0;
         trip_soft       <= 1'b0;
         trip_warn       <= 1'b0;
         for (int i = 0; i < NA; i++) begin
            if (cond_act[i]) begin
               case (actions_reg[i*lmaa_pkg::ACT_FW +: 3]) // RULE14
                  lmaa_pkg::ACT_HARD: trip_hard <= 1'b1;
                  lmaa_pkg::ACT_SOFT: trip_soft <= 1'b1;
                  lmaa_pkg::ACT_WARN: trip_warn <= 1'b1;
                  default:            ; // Unknown codes drive no trip
               endcase
            end
         end
      end
   end

   // Sticky events; a new event beats a same-cycle clear
   assign irq_ev = {as_req && !start_done, as_ok,
                    alarm_active & ~active_prev_reg};
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_stat_reg <= 8'h00;
      end else if (wr_stb && addr == lmaa_pkg::ADDR_IRQ_STAT) begin
         irq_stat_reg <= (irq_stat_reg & ~wdata[7:0]) | irq_ev;
      end else begin
         irq_stat_reg <= irq_stat_reg | irq_ev;
      end
   end
   assign irq = |(irq_stat_reg & irq_mask_reg);

   // Read mux; unmapped addresses read zero
   always_comb begin
      rd_mux = 32'h0;
      case (addr[7:4])
         lmaa_pkg::ADDR_LEVEL_BASE[7:4]:  rd_mux[7:0] = level_reg[addr[3:2]];
         lmaa_pkg::ADDR_DELAY_BASE[7:4]:  rd_mux[9:0] = delay_reg[addr[3:2]];
         lmaa_pkg::ADDR_MARGIN_BASE[7:4]: rd_mux[6:0] = margin_reg[addr[3:2]];
         default: begin
            case (addr)
               lmaa_pkg::ADDR_START_DELAY: rd_mux[9:0] = start_delay_reg;
               lmaa_pkg::ADDR_ACTIONS:     rd_mux[23:0] = actions_reg;
               lmaa_pkg::ADDR_DI_ASSIGN:   rd_mux[2*N_DI-1:0] = di_assign_reg;
               lmaa_pkg::ADDR_NORMAL_LOAD: rd_mux[8:0] =
                  {baseline_valid_reg, baseline_reg}; // RULE8
               lmaa_pkg::ADDR_STATUS:      rd_mux[7:0] =
                  {start_done, baseline_valid_reg, alarm_active};
               lmaa_pkg::ADDR_IRQ_STAT:    rd_mux[7:0] = irq_stat_reg;
               lmaa_pkg::ADDR_IRQ_MASK:    rd_mux[7:0] = irq_mask_reg;
               default:                    rd_mux = 32'h0;
            endcase
         end
      endcase
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata <= 32'h0;
      end else begin
         rdata <= rd_stb ? rd_mux : 32'h0;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   sequence s_as_accepted;
      as_req && start_done;
   endsequence

   a_autoset_reject: assert property (as_req && !start_done |=> // RULE10
      $stable(baseline_reg) && irq_stat_reg[lmaa_pkg::IRQ_AS_FAIL])
      else $error("rejected autoset changed baseline or no fail flag");
   a_autoset_capture: assert property (s_as_accepted |=> // RULE3
      baseline_valid_reg && baseline_reg == $past(shaft_power))
      else $error("autoset did not capture shaft power");
   a_high_levels: assert property (s_as_accepted |=> // RULE4
      level_reg[0] == sat_add($past(shaft_power), $past(margin_reg[0])) &&
      level_reg[1] == sat_add($past(shaft_power), $past(margin_reg[1])))
      else $error("high levels not baseline plus margin");
   a_low_levels: assert property (s_as_accepted |=> // RULE5
      level_reg[2] == sat_sub($past(shaft_power), $past(margin_reg[2])) &&
      level_reg[3] == sat_sub($past(shaft_power), $past(margin_reg[3])))
      else $error("low levels not baseline minus margin");
   a_margin_no_effect: assert property (mar_wr && !as_ok |=> // RULE6
      $stable(level_reg[0]) && $stable(level_reg[3]))
      else $error("margin write moved a live level");
   a_manual_off: assert property (lvl_wr && !as_ok |=> // RULE7
      !baseline_valid_reg)
      else $error("manual level write left baseline on");
   a_baseline_range: assert property (baseline_valid_reg |-> // RULE8
      baseline_reg <= lmaa_pkg::LEVEL_MAX || $past(as_ok))
      else $error("baseline outside range");
   a_start_hold: assert property (!run_cmd |-> ##2 // RULE2
      alarm_active[3:0] == 4'h0)
      else $error("load alarm active while stopped");
   a_ext_or: assert property (ext_req[0] && // RULE13
      actions_reg[16 +: 3] != lmaa_pkg::ACT_NONE |=> alarm_active[4])
      else $error("external alarm one not raised");
   a_edge_only: assert property (|as_edge |=> // RULE11
      (as_edge & $past(as_edge)) == '0)
      else $error("autoset retriggered on a held input level");
endmodule
`default_nettype wire

// >>> test/lmaa_plant_model.sv
// Far-side model: shaft power transducer and digital input pins.
// Assumes the bench calls its tasks from a single process.
`timescale 1ns/10ps
`default_nettype none
module lmaa_plant_model (
   input  wire logic       core_clk,
   output var  logic [7:0] shaft_power,
   output var  logic [3:0] din
);
   // Settled mid-range load and idle pins at time zero
   initial begin
      shaft_power = 8'h64;
      din         = 4'h0;
   end
   // Transducer never reports above 200 percent, so clamp here
   task automatic set_load(input int p);
      @(posedge core_clk);
      shaft_power <= (p > 200) ? 8'hC8 : 8'(p);
   endtask
   // Pins switch just after an edge; the block synchronises them
   task automatic set_pins(input logic [3:0] v);
      @(posedge core_clk);
      din <= v;
   endtask
endmodule
`default_nettype wire

// >>> test/tb.sv
// Self-checking bench for the load monitor alarm and autoset block.
// Assumes a tick of four clocks and four digital input pins.
`timescale 1ns/10ps
`default_nettype none
module tb;
   localparam logic [7:0] RA[14] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10,
      8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h40, 8'h4C, 8'h50};
   localparam logic [31:0] RV[14] = '{32'h74, 32'h6C, 32'h5C, 32'h54,
      32'h5, 32'h10, 32'h8, 32'h8, 32'h10, 32'hA, 32'h110000, 32'h0,
      32'h0, 32'h0};
   localparam int PW[5] = '{160, 145, 100, 55, 40};
   logic        core_clk = 1'b0;
   logic        rst_b    = 1'b0;
   logic        run_cmd  = 1'b0;
   logic [7:0]  addr     = 8'h00;
   logic [31:0] wdata    = 32'h0;
   logic        wr_stb   = 1'b0;
   logic        rd_stb   = 1'b0;
   logic [31:0] rdata;
   logic        irq;
   logic        trip_hard;
   logic        trip_soft;
   logic        trip_warn;
   logic [5:0]  alarm_active;
   logic [7:0]  shaft_power;
   logic [3:0]  din;
   int          failures = 0;
   int          checks   = 0;
   int          lv[4];
   int          mg[4];
   int          act[6];
   int          p;
   // Free-running 100 MHz clock
   always #5 core_clk = ~core_clk;
   lmaa_plant_model plant (.core_clk(core_clk), .shaft_power(shaft_power),
      .din(din));
   lmaa_load_monitor #(.N_DI(4), .TICK_CYCLES(4)) dut (
      .core_clk(core_clk), .rst_b(rst_b), .shaft_power(shaft_power),
      .run_cmd(run_cmd), .din(din), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .irq(irq),
      .trip_hard(trip_hard), .trip_soft(trip_soft),
      .trip_warn(trip_warn), .alarm_active(alarm_active));
   // Compare helpers and bus cycles
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string m);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t %s: got %h want %h", $time, m, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic wr(input int a, input int d);
      @(posedge core_clk);
      addr   <= 8'(a);
      wdata  <= 32'(d);
      wr_stb <= 1'b1;
      @(posedge core_clk);
      wr_stb <= 1'b0;
   endtask
   task automatic rc(input int a, input int e, input int k = -1);
      @(posedge core_clk);
      addr   <= 8'(a);
      rd_stb <= 1'b1;
      @(posedge core_clk);
      rd_stb <= 1'b0;
      #1 chk(rdata & 32'(k), 32'(e), $sformatf("read %h", a[7:0]));
   endtask
   // Model: threshold compare gated by a non-zero action
   function automatic logic [5:0] want(input int pw, input logic [3:0] d);
      logic [5:0] b;
      b = {d[2], d[0] | d[1], pw < lv[3], pw < lv[2], pw > lv[1], pw > lv[0]};
      for (int i = 0; i < 6; i++) if (act[i] == 0) b[i] = 1'b0;
      return b;
   endfunction
   task automatic chk_out(input logic [5:0] e);
      logic [2:0] t;
      t = 3'h0;
      for (int i = 0; i < 6; i++)
         if (e[i]) t |= {act[i] == 4, act[i] == 3, act[i] == 1};
      #1 chk({26'h0, alarm_active}, {26'h0, e}, "alarm set");
      chk({29'h0, trip_warn, trip_soft, trip_hard}, {29'h0, t}, "trips");
   endtask
   task automatic levels(input int a, input int b, input int c, input int d);
      lv = '{a, b, c, d};
      for (int i = 0; i < 4; i++) wr(4 * i, lv[i]);
   endtask
   task automatic conclude();
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Watchdog: the sequence needs about 730 clocks, allow over fifty times that
   initial begin
      #400_000;
      failures++;
      conclude();
   end
   // Main sequence
   initial begin
      p = $urandom(59438);
      act = '{0, 0, 0, 0, 1, 1};
      lv = '{116, 108, 92, 84};
      cyc(16);
      rst_b <= 1'b1;
      for (int i = 0; i < 14; i++) rc(RA[i], RV[i]);
      // Refused autoset while stopped, then irq mask and clear
      wr(8'h3C, 32'h1);
      rc(8'h48, 32'h80);
      #1 chk({31'h0, irq}, 32'h0, "irq masked");
      wr(8'h4C, 32'hC0);
      #1 chk({31'h0, irq}, 32'h1, "irq raised");
      wr(8'h48, 32'hC0);
      #1 chk({31'h0, irq}, 32'h0, "irq cleared");
      rc(8'h40, 32'h0);
      // Two-tick delays, one-second start delay, one code of each kind
      for (int i = 0; i < 4; i++) wr(32'h10 + 4 * i, 32'h2);
      wr(8'h30, 32'h1);
      act = '{1, 3, 4, 4, 3, 1};
      wr(8'h34, 32'h134431);
      plant.set_load(200);
      run_cmd <= 1'b1;
      wr(8'h3C, 32'h1);
      rc(8'h48, 32'h80, 32'hC0);
      cyc(20);
      chk_out(6'h00);
      cyc(60);
      chk_out(want(200, 4'h0));
      // Sweep: nothing early, then the full set once qualified
      levels(150, 140, 60, 50);
      for (int i = 0; i < 6; i++) begin
         p = (i < 5) ? PW[i] : $urandom_range(200);
         plant.set_load(100);
         cyc(10);
         plant.set_load(p);
         cyc(3);
         chk_out(6'h00);
         cyc(25);
         chk_out(want(p, 4'h0));
      end
      // Violations shorter than the delay must never qualify
      plant.set_load(100);
      cyc(6);
      wr(8'h48, 32'hFF);
      repeat (6) begin
         plant.set_load(160);
         cyc(2);
         plant.set_load(40);
         cyc(2);
      end
      plant.set_load(100);
      cyc(4);
      rc(8'h48, 32'h0, 32'h3F);
      // New margins stay idle until the next autoset
      for (int i = 0; i < 4; i++) begin
         mg[i] = 6 + $urandom_range(94);
         wr(32'h20 + 4 * i, mg[i]);
      end
      rc(8'h00, 32'h96);
      for (int i = 0; i < 3; i++) begin
         p = (i == 0) ? 20 + $urandom_range(160) : (i == 1) ? 195 : 5;
         plant.set_load(p);
         cyc(2);
         wr(8'h48, 32'hFF);
         wr(8'h3C, 32'h1);
         lv[0] = (p + mg[0] > 200) ? 200 : p + mg[0];
         lv[1] = (p + mg[1] > 200) ? 200 : p + mg[1];
         lv[2] = (p < mg[2]) ? 0 : p - mg[2];
         lv[3] = (p < mg[3]) ? 0 : p - mg[3];
         rc(8'h40, 32'h100 | p);
         for (int j = 0; j < 4; j++) rc(4 * j, lv[j]);
         rc(8'h48, 32'h40, 32'hC0);
      end
      wr(8'h04, 32'h82);
      rc(8'h40, 32'h0);
      rc(8'h04, 32'h82);
      // External alarms: every ext1 code, then random pin mixes
      levels(150, 140, 60, 50);
      plant.set_load(100);
      wr(8'h38, 32'hE5);
      for (int c = 0; c < 5; c++) if (c != 2) begin
         act[4] = c;
         wr(8'h34, 32'h104431 | (c << 16));
         plant.set_pins(4'h1);
         cyc(8);
         chk_out(want(100, 4'h1));
         plant.set_pins(4'h0);
         cyc(6);
      end
      repeat (8) begin
         p = $urandom_range(7);
         plant.set_pins(p[3:0]);
         cyc(8);
         chk_out(want(100, p[3:0]));
      end
      // Pin autoset fires once per rising edge, not on the level
      plant.set_pins(4'h0);
      p = 20 + $urandom_range(160);
      plant.set_load(p);
      cyc(4);
      wr(8'h48, 32'hFF);
      plant.set_pins(4'h8);
      cyc(12);
      rc(8'h40, 32'h100 | p);
      rc(8'h48, 32'h40, 32'hC0);
      chk({31'h0, irq}, 32'h1, "irq raised");
      wr(8'h48, 32'hFF);
      cyc(12);
      rc(8'h48, 32'h0, 32'hC0);
      // Stopped motor refuses autoset and keeps the baseline
      @(posedge core_clk) run_cmd <= 1'b0;
      wr(8'h3C, 32'h1);
      rc(8'h48, 32'h80, 32'hC0);
      rc(8'h40, 32'h100 | p);
      conclude();
   end
endmodule
`default_nettype wire
